// *** include/flag_pkg.sv ***
// Constants and types shared by the condition flag logic.
// Assumes a single 100 MHz core clock and an Avalon-MM register master.
// Contract
// - Accumulator store ORs bit30 xor bit29 into size
// - Limit latches on overflow or move limiting
// - Register transfer itself never sets limit
// - Extension clear when top five bits uniform
// - Sixteen-bit destinations use extended 20-bit result; 16-bit register results here repeat bit 15 instead
// - Thirty-two-bit destinations use extended 36-bit result
// - Extension ignores width bit, uses pre-limiter value
// - Saturation clears unnormalized flag
// - Unnormalized is xnor of two top bits
// - Size and limit ignore mode bits directly
// - Negative from bit 35, or 31 with width
// - Thirty-two and sixteen-bit accumulator results use 31
// - Negative uses pre-limiter value
// - Shift-right-accumulate negative bit 35 or 31
// - Integer multiply negative from product bit 30/15
// - Left shift clears negative when width set
// - Result flags change only on arithmetic results
// - Word test updates negative, zero, overflow
// - Sixteen-bit status word layout fixed
// - Reserved bits 14 to 10 read zero
// - Saturation sets overflow, else carry mismatch
// - Width bit selects 36 or 32-bit view
package flag_pkg;
  // Byte addresses of the status word and of the mode word
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_MODE   = 4'h4;
  localparam logic [15:0] STATUS_RST  = 16'h0300;
  localparam logic [15:0] STATUS_WMASK = 16'h83FF;
  // Flag positions
  localparam int BIT_C  = 0;
  localparam int BIT_V  = 1;
  localparam int BIT_Z  = 2;
  localparam int BIT_N  = 3;
  localparam int BIT_U  = 4;
  localparam int BIT_E  = 5;
  localparam int BIT_L  = 6;
  localparam int BIT_SIZE = 7;
  localparam int MODE_SAT = 0;
  localparam int MODE_CW  = 1;
  // Result size classes
  typedef enum logic [1:0] {
    SZ16 = 2'h0,
    SZ20 = 2'h1,
    SZ32 = 2'h2,
    SZ36 = 2'h3
  } res_size_t;
  // Instruction classes; shift-accumulate, multiply and left shift get special negative handling
  typedef enum logic [2:0] {
    OP_PLAIN  = 3'h0,
    OP_SHRACC = 3'h1,
    OP_IMUL   = 3'h2,
    OP_LSHL   = 3'h3,
    OP_WTEST  = 3'h4,
    OP_XFER   = 3'h5
  } op_class_t;
endpackage : flag_pkg

// *** include/flag_if.sv ***
`timescale 1ns/100ps
// Carries one computed flag set from the calculator to the status word.
interface flag_if;
  logic [7:0] flags;
  logic [7:0] upd_mask;
  modport calc (output flags, output upd_mask);
  modport sink (input flags, input upd_mask);
endinterface : flag_if

// *** src/flag_calc.sv ***
`timescale 1ns/100ps
// Combinational flag calculator for one arithmetic result.
// Assumes operands were already extended by the datapath.
module flag_calc
  import flag_pkg::*;
(
  // Result description
  input  wire logic [35:0] result_pre,
  input  wire res_size_t   res_size,
  input  wire logic        dest_acc,
  input  wire op_class_t   op_class,
  input  wire logic [30:0] integer_multiply_16_prod,
  input  wire logic        carry,
  input  wire logic        carry_msb_in,
  input  wire logic        saturated,
  input  wire logic        alu_valid,
  // Mode bits
  input  wire logic        sat_en,
  input  wire logic        cw_sel,
  // Computed flags
  flag_if.calc             fo
);
  logic [4:0] top5;
  logic       n_bit;
  logic       sat_hit;
  logic       u_bit;

  // Extension window: 20-bit results live in bits 35..16, so both use 35..31, except 16-bit register results, which repeat bit 15
  always_comb
  begin
    top5 = result_pre[35:31];
    if (res_size == SZ16 && !dest_acc)
      top5 = {result_pre[15], result_pre[15], result_pre[15], result_pre[15], result_pre[15]};
  end

  // Saturation only counts while the limiter is enabled
  assign sat_hit = sat_en & saturated;

  // Unnormalized from bits 31 and 30 (15 and 14 for 16-bit register results), cleared on saturation
  always_comb
  begin
    if (sat_hit)
      u_bit = 1'b0;
    else if (!dest_acc && res_size == SZ16)
      u_bit = ~(result_pre[15] ^ result_pre[14]);
    else
      u_bit = ~(result_pre[31] ^ result_pre[30]);
  end

  // Negative selection; pre-limiter value is always used
  always_comb
  begin
    n_bit = result_pre[35];
    unique case (op_class)
      OP_SHRACC: n_bit = sat_en ? result_pre[31] : result_pre[35];
      OP_IMUL:   n_bit = (sat_en | cw_sel) ? integer_multiply_16_prod[30] : integer_multiply_16_prod[15];
      default:
      begin
        if (!dest_acc)
          n_bit = result_pre[15];
        else if (res_size == SZ32 || res_size == SZ16)
          n_bit = result_pre[31];
        else
          n_bit = cw_sel ? result_pre[31] : result_pre[35];
        if (op_class == OP_LSHL && cw_sel)
          n_bit = 1'b0;
      end
    endcase
  end

  // Pack flags; zero and carry come from the datapath view
  always_comb
  begin
    fo.flags          = 8'h00;
    fo.flags[BIT_C]   = carry;
    fo.flags[BIT_V]   = sat_hit | (carry_msb_in ^ carry);
    fo.flags[BIT_Z]   = cw_sel ? (result_pre[31:0] == 32'h0000_0000) : (result_pre == 36'h0);
    fo.flags[BIT_N]   = n_bit;
    fo.flags[BIT_U]   = u_bit;
    fo.flags[BIT_E]   = ~((top5 == 5'h00) | (top5 == 5'h1F));
    fo.upd_mask       = 8'h00;
    if (alu_valid)
    begin
      if (op_class == OP_WTEST)
        fo.upd_mask = 8'h0E;
      else
        fo.upd_mask = 8'h3F;
    end
  end
endmodule : flag_calc

// *** src/condition_flag_logic.sv ***
`timescale 1ns/100ps
// Status word holding the condition flags, updated at result write-back.
// Assumes datapath strobes are on the core clock; Avalon-MM slave for software.
module condition_flag_logic
  import flag_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Arithmetic result
  input  wire logic        alu_valid,
  input  wire logic [35:0] result_pre,
  input  wire res_size_t   res_size,
  input  wire logic        dest_acc,
  input  wire op_class_t   op_class,
  input  wire logic [30:0] integer_multiply_16_prod,
  input  wire logic        carry,
  input  wire logic        carry_msb_in,
  input  wire logic        saturated,
  // Moves of an accumulator
  input  wire logic        acc_store,
  input  wire logic [35:0] acc_value,
  input  wire logic        move_limited,
  // Loop flag and explicit clears from decode
  input  wire logic        loop_set,
  input  wire logic        loop_clr,
  input  wire logic        sticky_clr,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Flag outputs to decode
  output logic [15:0]      status_word,
  output logic [1:0]       mode_bits
);
  flag_if     fb();
  logic [15:0] status_r;
  logic [1:0]  mode_r;
  logic        done_r;
  logic        bus_wr;
  logic [7:0]  merged;
  logic        lim_nxt;
  logic        sz_nxt;

  flag_calc u_calc (
    .result_pre   (result_pre),
    .res_size     (res_size),
    .dest_acc     (dest_acc),
    .op_class     (op_class),
    .integer_multiply_16_prod    (integer_multiply_16_prod),
    .carry        (carry),
    .carry_msb_in (carry_msb_in),
    .saturated    (saturated),
    .alu_valid    (alu_valid),
    .sat_en       (mode_r[MODE_SAT]),
    .cw_sel       (mode_r[MODE_CW]),
    .fo           (fb.calc)
  );

  // One wait state: request accepted on the second edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      done_r <= 1'b0;
    else
      done_r <= (read | write) & ~done_r;
  end
  assign bus_wr = write & done_r;

  // Sticky terms; overflow counts only outside the transfer itself, move limiting always counts
  always_comb
  begin
    lim_nxt = fb.flags[BIT_V] & alu_valid & (op_class != OP_XFER);
    lim_nxt = lim_nxt | move_limited;
    sz_nxt  = acc_store & (acc_value[30] ^ acc_value[29]);
    merged  = (status_r[7:0] & ~fb.upd_mask) | (fb.flags & fb.upd_mask);
  end

  // Status word; hardware sets win over clears in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status_r <= STATUS_RST;
    else
    begin
      if (bus_wr && address == ADDR_STATUS)
        status_r <= writedata[15:0] & STATUS_WMASK;
      else
      begin
        status_r[5:0] <= merged[5:0];
        if (sticky_clr)
          status_r[7:6] <= 2'b00;
        if (loop_clr)
          status_r[15] <= 1'b0;
      end
      if (lim_nxt)
        status_r[BIT_L] <= 1'b1;
      if (sz_nxt)
        status_r[BIT_SIZE] <= 1'b1;
      if (loop_set)
        status_r[15] <= 1'b1;
    end
  end

  // Mode word steering saturation and condition width
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mode_r <= 2'b00;
    else if (bus_wr && address == ADDR_MODE)
      mode_r <= writedata[1:0];
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (read && !done_r)
    begin
      if (address == ADDR_STATUS)
        readdata <= {16'h0000, status_r & STATUS_WMASK};
      else if (address == ADDR_MODE)
        readdata <= {30'h0, mode_r};
      else
        readdata <= 32'h0000_0000;
    end
  end

  // Wait request high until the answering edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~((read | write) & ~done_r);
  end

  // Registered copies for decode
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status_word <= STATUS_RST;
      mode_bits   <= 2'b00;
    end
    else
    begin
      status_word <= status_r;
      mode_bits   <= mode_r;
    end
  end

  property p_size_set;
    @(posedge clock) disable iff (rst)
      acc_store && (acc_value[30] ^ acc_value[29]) |=> status_r[BIT_SIZE];
  endproperty
  a_size_set: assert property (p_size_set) else $error("size flag not set");

  property p_limit_set;
    @(posedge clock) disable iff (rst)
      move_limited |=> status_r[BIT_L];
  endproperty
  a_limit_set: assert property (p_limit_set) else $error("limit flag not set");

  property p_xfer_no_limit;
    @(posedge clock) disable iff (rst)
      alu_valid && op_class == OP_XFER && !move_limited && !status_r[BIT_L]
      && !(write && address == ADDR_STATUS) |=> !status_r[BIT_L];
  endproperty
  a_xfer_no_limit: assert property (p_xfer_no_limit) else $error("transfer set limit");

  property p_ext;
    @(posedge clock) disable iff (rst)
      alu_valid && op_class == OP_PLAIN && dest_acc && !bus_wr
      |=> status_r[BIT_E] == !($past(result_pre[35:31]) == 5'h00
                               || $past(result_pre[35:31]) == 5'h1F);
  endproperty
  a_ext: assert property (p_ext) else $error("extension flag wrong");

  property p_unnorm_sat;
    @(posedge clock) disable iff (rst)
      alu_valid && op_class == OP_PLAIN && mode_r[MODE_SAT] && saturated && !bus_wr
      |=> !status_r[BIT_U] && status_r[BIT_V];
  endproperty
  a_unnorm_sat: assert property (p_unnorm_sat) else $error("saturation flags wrong");

  property p_hold;
    @(posedge clock) disable iff (rst)
      !alu_valid && !bus_wr |=> status_r[5:0] == $past(status_r[5:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("result flags moved");

  property p_reserved;
    @(posedge clock) disable iff (rst)
      status_r[14:10] == 5'h00 && status_word[14:10] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_lshl;
    @(posedge clock) disable iff (rst)
      alu_valid && op_class == OP_LSHL && mode_r[MODE_CW] && !bus_wr |=> !status_r[BIT_N];
  endproperty
  a_lshl: assert property (p_lshl) else $error("shift negative not cleared");

  property p_wtest;
    @(posedge clock) disable iff (rst)
      alu_valid && op_class == OP_WTEST && !bus_wr
      |=> status_r[BIT_C] == $past(status_r[BIT_C]) && status_r[BIT_U] == $past(status_r[BIT_U]);
  endproperty
  a_wtest: assert property (p_wtest) else $error("word test touched other flags");
endmodule : condition_flag_logic

// *** testbench/alu_result_model.sv ***
// Datapath model: presents one arithmetic result per request.
// Assumes requests arrive from the bench on the core clock.
`timescale 1ns/100ps
module alu_result_model
  import flag_pkg::*;
(
  // Clock and request
  input  wire logic        clock,
  input  wire logic        go,
  input  wire res_size_t   rsz,
  input  wire logic        acc,
  input  wire op_class_t   op,
  input  wire logic [35:0] r,
  input  wire logic [30:0] p,
  input  wire logic [2:0]  csc,
  // Result toward the flag logic
  output logic             alu_valid,
  output res_size_t        res_size,
  output logic             dest_acc,
  output op_class_t        op_class,
  output logic [35:0]      result_pre,
  output logic [30:0]      integer_multiply_16_prod,
  output logic [2:0]       cflags
);
  // Result stands one cycle; idle data flips so stale values never look fresh
  always_ff @(posedge clock)
  begin
    alu_valid <= go;
    if (go)
    begin
      res_size   <= rsz;
      dest_acc   <= acc;
      op_class   <= op;
      result_pre <= r;
      integer_multiply_16_prod  <= p;
      cflags     <= csc;
    end
    else
    begin
      result_pre <= ~result_pre;
      integer_multiply_16_prod  <= ~integer_multiply_16_prod;
      cflags     <= ~cflags;
    end
  end
endmodule : alu_result_model

// *** testbench/condition_flag_logic_tb_top.sv ***
// Self-checking bench for the condition flag logic.
// Assumes the flag package and the datapath model are compiled first.
`timescale 1ns/100ps
module condition_flag_logic_tb_top
  import flag_pkg::*;
  ;
  typedef struct packed {
    res_size_t   rsz;
    logic        acc;
    op_class_t   op;
    logic [1:0]  md;
    logic [35:0] r;
    logic [30:0] p;
    logic [2:0]  csc;
    logic [7:0]  m;
    logic [7:0]  e;
  } row_t;
  logic        clock;
  logic        rst;
  logic [5:0]  go;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] status_word;
  logic [1:0]  mode_bits;
  logic [35:0] acc_value;
  logic        alu_valid;
  res_size_t   res_size;
  logic        dest_acc;
  op_class_t   op_class;
  logic [35:0] result_pre;
  logic [30:0] integer_multiply_16_prod;
  logic [2:0]  cflags;
  logic [31:0] rd;
  row_t        cur;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // Mode {width,sat}, result, product, {carry,carry in,saturated}, mask, expected
  row_t rows [14] = '{
    '{SZ36,1'h1,OP_PLAIN,2'h0,36'h800000000,31'h0,3'h0,8'h38,8'h38},
    '{SZ36,1'h1,OP_PLAIN,2'h2,36'h080000000,31'h0,3'h0,8'h38,8'h28},
    '{SZ16,1'h0,OP_PLAIN,2'h0,36'h00000C000,31'h0,3'h0,8'h18,8'h18},
    '{SZ32,1'h1,OP_PLAIN,2'h2,36'h0C0000000,31'h0,3'h0,8'h38,8'h38},
    '{SZ36,1'h1,OP_SHRACC,2'h1,36'h080000000,31'h0,3'h0,8'h08,8'h08},
    '{SZ36,1'h1,OP_SHRACC,2'h0,36'h080000000,31'h0,3'h0,8'h08,8'h00},
    '{SZ16,1'h0,OP_IMUL,2'h0,36'h0,31'h40000000,3'h0,8'h08,8'h00},
    '{SZ16,1'h0,OP_IMUL,2'h1,36'h0,31'h40000000,3'h0,8'h08,8'h08},
    '{SZ36,1'h1,OP_LSHL,2'h2,36'h880000000,31'h0,3'h0,8'h08,8'h00},
    '{SZ36,1'h1,OP_LSHL,2'h0,36'h880000000,31'h0,3'h0,8'h08,8'h08},
    '{SZ36,1'h1,OP_PLAIN,2'h1,36'h0,31'h0,3'h1,8'h52,8'h42},
    '{SZ36,1'h1,OP_PLAIN,2'h0,36'h0,31'h0,3'h4,8'h42,8'h42},
    '{SZ36,1'h1,OP_XFER,2'h1,36'h0,31'h0,3'h1,8'h40,8'h00},
    '{SZ36,1'h1,OP_WTEST,2'h0,36'h0,31'h0,3'h0,8'h0E,8'h04}
  };
  // Far-side datapath and the block under test
  alu_result_model u_model (.clock(clock), .go(go[0]), .rsz(cur.rsz), .acc(cur.acc),
    .op(cur.op), .r(cur.r), .p(cur.p), .csc(cur.csc), .alu_valid(alu_valid),
    .res_size(res_size), .dest_acc(dest_acc), .op_class(op_class),
    .result_pre(result_pre), .integer_multiply_16_prod(integer_multiply_16_prod), .cflags(cflags));
  condition_flag_logic u_dut (.clock(clock), .rst(rst), .alu_valid(alu_valid),
    .result_pre(result_pre), .res_size(res_size), .dest_acc(dest_acc),
    .op_class(op_class), .integer_multiply_16_prod(integer_multiply_16_prod), .carry(cflags[2]),
    .carry_msb_in(cflags[1]), .saturated(cflags[0]), .acc_store(go[1]),
    .acc_value(acc_value), .move_limited(go[2]), .loop_set(go[4]), .loop_clr(go[5]),
    .sticky_clr(go[3]), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .status_word(status_word), .mode_bits(mode_bits));
  // Core clock
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until waitrequest is seen low at an edge; data taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do
      @(posedge clock);
    while (waitrequest !== 1'h0);
    rd = readdata;
    write <= 1'h0;
    read  <= 1'h0;
  endtask : bus
  // One-cycle strobes; waits until the status copy has settled
  task automatic fire(input logic [5:0] v, input logic [35:0] av);
    @(posedge clock);
    go        <= v;
    acc_value <= av;
    @(posedge clock);
    go        <= 6'h00;
    acc_value <= ~av;
    repeat (2) @(posedge clock);
    #1;
  endtask : fire
  // Main sequence
  initial
  begin
    rst = 1'h1;
    go = 6'h00;
    address = 4'h0;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    acc_value = 36'h0;
    cur = rows[0];
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    #1;
    chk("status reset", {16'h0, status_word}, {16'h0, STATUS_RST});
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status read", rd, {16'h0, STATUS_RST});
    foreach (rows[i])
    begin
      cur = rows[i];
      bus(1'h1, ADDR_MODE, {30'h0, cur.md});
      fire(6'h08, 36'h0);
      fire(6'h01, 36'h0);
      chk($sformatf("row %0d", i), {24'h0, status_word[7:0] & cur.m}, {24'h0, cur.e});
    end
    // Size flag latches only from bit 30 xor bit 29 of a stored accumulator
    fire(6'h08, 36'h0);
    fire(6'h02, 36'h060000000);
    chk("size equal", {31'h0, status_word[BIT_SIZE]}, 32'h0);
    fire(6'h02, 36'h040000000);
    fire(6'h02, 36'h0);
    chk("size sticky", {31'h0, status_word[BIT_SIZE]}, 32'h1);
    fire(6'h04, 36'h0);
    chk("limit move", {31'h0, status_word[BIT_L]}, 32'h1);
    fire(6'h08, 36'h0);
    chk("sticky clear", {24'h0, status_word[7:0] & 8'hC0}, 32'h0);
    fire(6'h10, 36'h0);
    chk("loop set", {31'h0, status_word[15]}, 32'h1);
    fire(6'h20, 36'h0);
    chk("loop clear", {31'h0, status_word[15]}, 32'h0);
    // Reserved bits stay zero; idle datapath noise must not move any flag
    bus(1'h1, ADDR_STATUS, 32'hFFFFFFFF);
    repeat (6) @(posedge clock);
    #1;
    chk("status idle", {16'h0, status_word}, 32'h000083FF);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("reserved", rd, 32'h000083FF);
    bus(1'h1, ADDR_MODE, 32'h3);
    bus(1'h0, ADDR_MODE, 32'h0);
    chk("mode read", rd, 32'h00000003);
    chk("mode bits", {30'h0, mode_bits}, 32'h00000003);
    bus(1'h0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    wrap_up();
  end
endmodule : condition_flag_logic_tb_top
